/* core/wdc_map.svh */
// Register address, field positions, reset values and counting constants of the watchdog
`ifndef WDC_MAP_SVH
`define WDC_MAP_SVH

`define WDC_SFR_ADDR 8'hC0
`define WDC_CTRL_RESET 8'h10
`define WDC_BIT_UNLOCK 0
`define WDC_BIT_ARM 1
`define WDC_BIT_FLAG 2
`define WDC_BIT_IRQSEL 3
`define WDC_PRE_MSB 7
`define WDC_PRE_LSB 4
`define WDC_PRE_IMMEDIATE 4'h8
`define WDC_PRE_MAX_VALID 4'h7
`define WDC_BASE_TICKS 512
`define WDC_PRE_SPAN 7

`endif

/* core/wdc_pkg.sv */
// Types shared by the watchdog design
package wdc_pkg;

    typedef struct packed {
        logic [3:0] timeout_prescale;
        logic irq_response_sel;
        logic timeout_flag;
        logic watchdog_arm;
        logic write_unlock;
    } wdc_ctrl_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wdc_sfr_req_type;

    // Gray-coded unlock window states
    typedef enum logic [1:0] {
        WDC_LOCKED = 2'b00,
        WDC_OPEN = 2'b01
    } wdc_unlock_type;

endpackage : wdc_pkg

/* core/wdc_watchdog.sv */
// Watchdog timer with unlock-protected control register, counted on crystal clock edges
`timescale 1ns/1ps
`include "wdc_map.svh"
// Overview of operation
// [RULE1] Timeout lasts 512 crystal periods times two to the prescale, codes 0..7.
// [RULE2] Counter advances only on crystal clock edges, never on core clock alone.
// [RULE3] Prescale 1000b resets at once; codes above 1000b never time out.
// [RULE4] Bit 3 set turns a timeout into an interrupt instead of a reset, except at prescale 1000b.
// [RULE5] With interrupt response the watchdog repeats as a periodic general timer.
// [RULE6] Bit 2 flag is set on every watchdog timeout.
// [RULE7] Flag clears by writing 0 or hardware reset; watchdog reset keeps it.
// [RULE8] Setting arm bit 1 enables the watchdog and clears its counter.
// [RULE9] Without a re-arm inside the period, a reset or interrupt is issued.
// [RULE10] Arm clears on write 0, watchdog reset, hardware reset, supply monitor interrupt.
// [RULE11] Register write is accepted only right after an unlock step setting bit 0.
// [RULE12] Software disables global interrupts before the unlock sequence.
// [RULE13] Software writes the register in the instruction right after the unlock.
// [RULE14] Writes not directly after unlock are ignored; window closes after one access.
// [RULE15] Crystal edges are detected in the core domain; events stay in that domain.
module wdc_watchdog #(
    parameter int BASE_TICKS = `WDC_BASE_TICKS
) (
    input wire logic mclk_i,                        // Core clock, 100 MHz
    input wire logic reset_n_i,                     // Hardware reset, active low, synchronous
    input wire logic xtal_clk_i,                    // 32.768 kHz crystal clock level
    input wire logic supply_monitor_irq_i,          // Supply monitor interrupt pulse
    input wire wdc_pkg::wdc_sfr_req_type sfr_req_i, // Core SFR access
    output logic [7:0] sfr_rdata_o,                 // Read data, valid cycle after read
    output logic wdt_reset_o,                       // System reset request pulse
    output logic wdt_irq_o                          // Watchdog interrupt pulse
);
    import wdc_pkg::*;

    localparam int CNT_W = $clog2(BASE_TICKS) + `WDC_PRE_SPAN;

    if (BASE_TICKS < 1 || (BASE_TICKS & (BASE_TICKS - 1)) != 0) begin : g_base_check
        $error("BASE_TICKS must be a power of two");
    end

    // ******************************************************
    // Timeout decoding
    // ******************************************************
    function automatic logic [CNT_W-1:0] wdc_last(input logic [3:0] pre);
        logic [31:0] span;
        span = 32'(BASE_TICKS) << pre[2:0];
        wdc_last = CNT_W'(span - 32'd1); // RULE1
    endfunction : wdc_last

    function automatic logic wdc_valid(input logic [3:0] pre);
        wdc_valid = (pre <= `WDC_PRE_MAX_VALID);
    endfunction : wdc_valid

    wdc_ctrl_type ctrl;
    wdc_ctrl_type next_ctrl;
    wdc_unlock_type state;
    wdc_unlock_type next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic xtal_q;

    // ******************************************************
    // Access decode and unlock window
    // ******************************************************
    wire hit = (sfr_req_i.addr == `WDC_SFR_ADDR);
    wire wr_hit = sfr_req_i.wr && hit;
    wire any_acc = sfr_req_i.wr || sfr_req_i.rd;
    wire accept = wr_hit && (state == WDC_OPEN); // RULE11
    wire unlock_req = wr_hit && (state == WDC_LOCKED) && sfr_req_i.wdata[`WDC_BIT_UNLOCK];
    wire rearm = accept && sfr_req_i.wdata[`WDC_BIT_ARM]; // RULE8

    always_comb begin
        next_state = state;
        case (state)
            WDC_LOCKED: begin
                if (unlock_req) begin
                    next_state = WDC_OPEN; // RULE11
                end
            end
            WDC_OPEN: begin
                // Any other access while open closes the window unwritten
                if (any_acc) begin
                    next_state = WDC_LOCKED; // RULE14
                end
            end
            default: begin
                next_state = WDC_LOCKED;
            end
        endcase
    end

    // ******************************************************
    // Crystal edge detect and timeout
    // ******************************************************
    // Edge seen when the crystal level rose since the last core edge
    wire tick = xtal_clk_i && !xtal_q; // RULE2 RULE15
    wire pre_imm = (ctrl.timeout_prescale == `WDC_PRE_IMMEDIATE);
    wire pre_ok = wdc_valid(ctrl.timeout_prescale); // RULE3
    wire at_last = (cnt == wdc_last(ctrl.timeout_prescale));
    wire timeout = ctrl.watchdog_arm && !rearm && (pre_imm || (pre_ok && tick && at_last)); // RULE9
    wire reset_evt = timeout && (!ctrl.irq_response_sel || pre_imm); // RULE3 RULE4
    wire irq_evt = timeout && !reset_evt; // RULE4 RULE5

    // Codes 9 and above hold the count; code 8 clears it
    assign next_cnt = (rearm || !ctrl.watchdog_arm || timeout) ? '0 : // RULE8 RULE5
                      (tick && pre_ok) ? cnt + 1'b1 : cnt; // RULE2

    // ******************************************************
    // Control register next value
    // ******************************************************
    wire wr_irqsel = sfr_req_i.wdata[`WDC_BIT_IRQSEL];
    wire clr_arm = reset_evt || supply_monitor_irq_i; // RULE10

    always_comb begin
        next_ctrl = ctrl;
        next_ctrl.write_unlock = (next_state == WDC_OPEN);
        if (accept) begin
            next_ctrl.timeout_prescale = sfr_req_i.wdata[`WDC_PRE_MSB:`WDC_PRE_LSB];
            next_ctrl.irq_response_sel = wr_irqsel;
            next_ctrl.watchdog_arm = sfr_req_i.wdata[`WDC_BIT_ARM];
            if (!sfr_req_i.wdata[`WDC_BIT_FLAG]) begin
                next_ctrl.timeout_flag = 1'b0; // RULE7
            end
        end
        if (clr_arm) begin
            next_ctrl.watchdog_arm = 1'b0; // RULE10
        end
        // A timeout wins over a same-cycle write of 0 to the flag
        if (timeout) begin
            next_ctrl.timeout_flag = 1'b1; // RULE6
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            ctrl <= wdc_ctrl_type'(`WDC_CTRL_RESET); // RULE7 RULE10
            state <= WDC_LOCKED;
            cnt <= '0;
            xtal_q <= 1'b0;
            sfr_rdata_o <= 8'h00;
            wdt_reset_o <= 1'b0;
            wdt_irq_o <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            state <= next_state;
            cnt <= next_cnt;
            xtal_q <= xtal_clk_i;
            sfr_rdata_o <= (sfr_req_i.rd && hit) ? ctrl : 8'h00;
            wdt_reset_o <= reset_evt;
            wdt_irq_o <= irq_evt;
        end
    end

    // ******************************************************
    // Assertions
    // ******************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    sequence unlock_seq;
        unlock_req;
    endsequence

    sequence stray_access_seq;
        state == WDC_OPEN && any_acc && !wr_hit;
    endsequence

    reset_pulse_a: assert property (reset_evt |=> wdt_reset_o && !ctrl.watchdog_arm) // RULE9
        else $error("watchdog reset not issued or arm not cleared");
    flag_set_a: assert property (timeout |=> ctrl.timeout_flag) // RULE6
        else $error("timeout flag not set on timeout");
    flag_keep_a: assert property (wdt_reset_o |-> ctrl.timeout_flag) // RULE7
        else $error("watchdog reset cleared the timeout flag");
    locked_write_a: assert property (wr_hit && state == WDC_LOCKED |=> // RULE14
        $stable(ctrl.timeout_prescale) && $stable(ctrl.irq_response_sel))
        else $error("locked write changed the register");
    unlock_close_a: assert property (stray_access_seq |=> state == WDC_LOCKED // RULE14
        ##0 !ctrl.write_unlock)
        else $error("unlock window stayed open after other access");
    unlock_write_a: assert property (unlock_seq ##1 wr_hit |=> // RULE11
        ctrl.timeout_prescale == $past(sfr_req_i.wdata[`WDC_PRE_MSB:`WDC_PRE_LSB]))
        else $error("write after unlock not accepted");
    immediate_a: assert property (ctrl.watchdog_arm && pre_imm && !rearm |=> wdt_reset_o) // RULE3
        else $error("immediate reset code did not reset");
    reserved_a: assert property (ctrl.watchdog_arm && !pre_ok && !pre_imm && !rearm |-> // RULE3
        !timeout ##1 (cnt == $past(cnt)))
        else $error("reserved prescale produced a timeout");
    irq_mode_a: assert property (irq_evt && !accept && !supply_monitor_irq_i |=> // RULE5
        wdt_irq_o && ctrl.watchdog_arm && !wdt_reset_o)
        else $error("interrupt response did not keep timer running");
    rearm_clear_a: assert property (rearm |=> cnt == '0) // RULE8
        else $error("arm write did not clear the counter");
    supply_clear_a: assert property (supply_monitor_irq_i |=> !ctrl.watchdog_arm) // RULE10
        else $error("supply monitor interrupt did not clear arm");
    no_tick_hold_a: assert property (!tick && !rearm && ctrl.watchdog_arm && !timeout |=> // RULE2
        cnt == $past(cnt))
        else $error("counter moved without a crystal edge");

    // ******************************************************
    // Register window properties
    // ******************************************************
    window_open_a: assert property (unlock_req |=> // RULE11
        state == WDC_OPEN && ctrl.write_unlock)
        else $error("unlock step did not open the window");
    flag_clear_a: assert property (accept && !sfr_req_i.wdata[`WDC_BIT_FLAG] // RULE7
        && !timeout |=> !ctrl.timeout_flag)
        else $error("write of 0 did not clear the timeout flag");
    arm_write_a: assert property (accept && !sfr_req_i.wdata[`WDC_BIT_ARM] |=> // RULE10
        !ctrl.watchdog_arm)
        else $error("write of 0 did not clear the arm bit");

    // ******************************************************
    // Timeout properties
    // ******************************************************
    sequence last_tick_seq;
        ctrl.watchdog_arm && pre_ok && tick && at_last && !rearm;
    endsequence

    timeout_fire_a: assert property (last_tick_seq |=> wdt_reset_o || wdt_irq_o) // RULE9
        else $error("last crystal edge of the period gave no response");
    reset_once_a: assert property (wdt_reset_o |=> !wdt_reset_o) // RULE9
        else $error("watchdog reset pulse lasted more than one cycle");
    irq_restart_a: assert property (irq_evt |=> cnt == '0) // RULE5
        else $error("interrupt response did not restart the count");
    count_step_a: assert property (tick && pre_ok && ctrl.watchdog_arm && !rearm // RULE2
        && !timeout |=> cnt == CNT_W'($past(cnt) + 1'b1))
        else $error("counter did not advance on a crystal edge");

endmodule : wdc_watchdog

/* test/wdc_cpu.sv */
// Core model that drives the watchdog register bus
`timescale 1ns/1ps
`include "wdc_map.svh"
module wdc_cpu (
    input wire logic mclk_i, // Core clock
    input wire logic [7:0] rdata_i, // Read data
    output wdc_pkg::wdc_sfr_req_type req_o // Register access
);
    import wdc_pkg::*;
    initial req_o = '0;
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge mclk_i);
        req_o = '{w, !w, a, d};
        @(negedge mclk_i);
        q = rdata_i;
        req_o = '{1'b0, 1'b0, ~a, ~d};
    endtask : acc
    // Interrupts held off; the unlock is followed at once by the write
    task automatic locked_wr(input logic [7:0] d);
        @(negedge mclk_i);
        req_o = '{1'b1, 1'b0, `WDC_SFR_ADDR, 8'h01};
        @(negedge mclk_i);
        req_o = '{1'b1, 1'b0, `WDC_SFR_ADDR, d};
        @(negedge mclk_i);
        req_o = '{1'b0, 1'b0, ~`WDC_SFR_ADDR, ~d};
    endtask : locked_wr
endmodule : wdc_cpu

/* test/tb.sv */
// Self-checking bench for the watchdog
`timescale 1ns/1ps
`include "wdc_map.svh"
module tb;
    import wdc_pkg::*;
    logic mclk = 0;
    logic reset_n = 0;
    logic xtal = 0;
    logic xq = 0;
    logic supply_monitor = 0;
    logic [7:0] rdata;
    logic [7:0] dummy;
    logic wreset;
    logic wirq;
    wdc_sfr_req_type req;
    int errors = 0;
    int comparisons = 0;
    int edges = 0;
    int xdiv = 0;
    always #5 mclk = ~mclk;
    // Crystal stand-in, 20 core cycles a period
    always @(negedge mclk) begin
        xdiv <= (xdiv == 9) ? 0 : xdiv + 1;
        if (xdiv == 9) xtal <= ~xtal;
    end
    always @(posedge mclk) begin
        xq <= xtal;
        if (xtal && !xq) edges <= edges + 1;
    end
    wdc_watchdog #(.BASE_TICKS(4)) uut (.mclk_i(mclk), .reset_n_i(reset_n), .xtal_clk_i(xtal),
        .supply_monitor_irq_i(supply_monitor), .sfr_req_i(req), .sfr_rdata_o(rdata),
        .wdt_reset_o(wreset), .wdt_irq_o(wirq));
    wdc_cpu cpu (.mclk_i(mclk), .rdata_i(rdata), .req_o(req));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic ctrl(input logic [7:0] exp);
        logic [7:0] q;
        cpu.acc(1'b0, `WDC_SFR_ADDR, 8'h00, q);
        check(q, exp);
    endtask : ctrl
    // Arms just after a crystal edge, then counts edges until the pulse
    task automatic timeout(input logic [7:0] d, input logic irq, input int exp);
        int base;
        @(posedge xtal);
        @(negedge mclk);
        base = edges;
        cpu.locked_wr(d);
        repeat (3000) begin
            @(negedge mclk);
            if ((irq ? wirq : wreset) === 1'b1) break;
        end
        check(8'(edges - base), 8'(exp));
    endtask : timeout
    task automatic t_lock;
        ctrl(8'h10);
        cpu.acc(1'b1, `WDC_SFR_ADDR, 8'h72, dummy);
        ctrl(8'h10);
        cpu.acc(1'b1, `WDC_SFR_ADDR, 8'h01, dummy);
        ctrl(8'h11);
        cpu.acc(1'b1, `WDC_SFR_ADDR, 8'h72, dummy);
        ctrl(8'h10);
        cpu.acc(1'b1, `WDC_SFR_ADDR, 8'h01, dummy);
        cpu.acc(1'b0, 8'h3C, 8'h00, dummy);
        check(dummy, 8'h00);
        ctrl(8'h10);
    endtask : t_lock
    task automatic t_reset;
        timeout(8'h02, 1'b0, 4);
        ctrl(8'h04);
        cpu.locked_wr(8'h00);
        ctrl(8'h00);
    endtask : t_reset
    task automatic t_irq;
        timeout(8'h1A, 1'b1, 8);
        ctrl(8'h1E);
    endtask : t_irq
    task automatic t_psm;
        cpu.locked_wr(8'h12);
        @(negedge mclk);
        supply_monitor = 1'b1;
        @(negedge mclk);
        supply_monitor = 1'b0;
        ctrl(8'h10);
    endtask : t_psm
    task automatic t_now;
        timeout(8'h82, 1'b0, 0);
        ctrl(8'h84);
        @(negedge mclk);
        reset_n = 1'b0;
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        ctrl(8'h10);
    endtask : t_now
    // Reserved code 9 must neither time out nor interrupt over many crystal edges
    task automatic t_rsvd;
        int seen;
        seen = 0;
        cpu.locked_wr(8'h92);
        repeat (400) begin
            @(negedge mclk);
            if (wreset === 1'b1 || wirq === 1'b1) seen++;
        end
        check(8'(seen), 8'h00);
        ctrl(8'h92);
    endtask : t_rsvd
    task automatic stop_test;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (12) @(negedge mclk);
        reset_n = 1'b1;
        t_lock;
        t_reset;
        t_irq;
        t_psm;
        t_now;
        t_rsvd;
        stop_test;
    end
    initial begin
        #200000;
        errors++;
        stop_test;
    end
endmodule : tb
